/* File: design/wim_pkg.sv */
package wim_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] ADDR_WAKE_ENABLE_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_BIAS_CURRENT_CTRL     = 4'h1;
  localparam logic [3:0] ADDR_FILTER_MODE_CTRL      = 4'h2;
  localparam logic [3:0] ADDR_MEASURE_CTRL          = 4'h3;
  localparam logic [3:0] ADDR_WAKE_EVENT_STATUS     = 4'h4;
  localparam logic [3:0] ADDR_ALT_WAKE_EVENT_STATUS = 4'h5;
  localparam logic [3:0] ADDR_PIN_LEVEL_STATUS      = 4'h6;
  localparam logic [3:0] ADDR_MODE_CTRL             = 4'h7;
  localparam logic [3:0] ADDR_FAULT_STATUS          = 4'h8;

  localparam logic [7:0] RST_WAKE_ENABLE = 8'h00;
  localparam logic [7:0] RST_BIAS        = 8'h00;
  localparam logic [7:0] RST_FILTER      = 8'h00;

  // ****************************************
  // codes
  // ****************************************
  localparam logic [1:0] BIAS_NONE = 2'h0;
  localparam logic [1:0] BIAS_DOWN = 2'h1;
  localparam logic [1:0] BIAS_UP   = 2'h2;
  localparam logic [1:0] BIAS_AUTO = 2'h3;

  localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
  localparam logic [1:0] FLT_STATIC_LONG  = 2'h1;
  localparam logic [1:0] FLT_CYCLIC_A     = 2'h2;
  localparam logic [1:0] FLT_CYCLIC_B     = 2'h3;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_FAILSAFE
  } wim_mode_e;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ           = 25;
  localparam int FILTER_SHORT_US   = 16;
  localparam int FILTER_LONG_US    = 64;
  localparam int FILTER_SHORT_CYC  = FILTER_SHORT_US * CLK_MHZ;
  localparam int FILTER_LONG_CYC   = FILTER_LONG_US * CLK_MHZ;
  localparam int FILTER_CNT_W      = 11;

endpackage : wim_pkg

/* File: design/wim_wake_input_monitor.sv */
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
module wim_wake_input_monitor
  import wim_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [2:0] i_wake_input_pin,
  input  wire logic [1:0] i_alt_fail_output_pins,
  input  wire logic       i_alt_pins_as_wake,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_sleep_cmd,
  input  wire logic       i_cycle_timer_a_window,
  input  wire logic       i_cycle_timer_b_window,
  output logic      [7:0] o_rdata,
  output logic      [2:0] o_pull_up_en,
  output logic      [2:0] o_pull_down_en,
  output logic            o_measure_switch,
  output logic            o_irq_req,
  output logic            o_wake_req,
  output logic            o_cmd_fault,
  output logic            o_restart_req
);

  localparam int NCH = 5;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [NCH-1:0]                   sync1;
    logic [NCH-1:0]                   sync2;
    logic [NCH-1:0]                   stable;
    logic [NCH-1:0]                   qual;
    logic [NCH-1:0][FILTER_CNT_W-1:0] cnt;
    logic [NCH-1:0]                   armed;
    logic [2:0]                       win_q;
    logic [7:0]                       wake_en;
    logic [7:0]                       bias;
    logic [7:0]                       filt;
    logic                             meas_en;
    logic [2:0]                       wk_stat;
    logic [1:0]                       alt_stat;
    logic [2:0]                       lvl;
    logic                             fault;
    logic [7:0]                       rdata;
    logic [2:0]                       pu;
    logic [2:0]                       pd;
    logic                             sw;
    logic                             irq;
    logic                             wake;
    logic                             restart;
  } wim_state_s;

  wim_state_s s_q;
  wim_state_s s_d;

  wim_mode_e mode;
  assign mode = wim_mode_e'(i_mode);

  logic [NCH-1:0] raw;
  assign raw = {i_alt_fail_output_pins, i_wake_input_pin};

  always_comb
  begin
    logic [NCH-1:0]          ev;
    logic [2:0]              win;
    logic [2:0]              gate;
    logic [1:0]              fc;
    logic [1:0]              bc;
    logic [FILTER_CNT_W-1:0] lim;
    logic                    act;
    logic                    clr_wk;
    logic                    clr_alt;
    logic                    clr_flt;
    logic                    low_power;
    ev        = '0;
    win       = '0;
    gate      = '0;
    fc        = '0;
    bc        = '0;
    lim       = '0;
    act       = 1'b0;
    clr_wk    = 1'b0;
    clr_alt   = 1'b0;
    clr_flt   = 1'b0;
    low_power = (mode == MODE_SLEEP) || (mode == MODE_FAILSAFE);
    s_d       = s_q;

    // ****************************************
    // register port
    // ****************************************
    if (i_wr)
    begin
      unique case (i_addr)
        ADDR_WAKE_ENABLE_CTRL: s_d.wake_en = {5'h00, i_wdata[2:0]};
        ADDR_BIAS_CURRENT_CTRL: s_d.bias = {2'h0, i_wdata[5:0]};
        ADDR_FILTER_MODE_CTRL: s_d.filt = {2'h0, i_wdata[5:0]};
        ADDR_MEASURE_CTRL: s_d.meas_en = i_wdata[0];
        default: ;
      endcase
    end
    // read clears latched flags; set below still wins
    if (i_rd)
    begin
      s_d.rdata = 8'h00;
      unique case (i_addr)
        ADDR_WAKE_ENABLE_CTRL: s_d.rdata = s_q.wake_en;
        ADDR_BIAS_CURRENT_CTRL: s_d.rdata = s_q.bias;
        ADDR_FILTER_MODE_CTRL: s_d.rdata = s_q.filt;
        ADDR_MEASURE_CTRL: s_d.rdata = {7'h00, s_q.meas_en};
        ADDR_WAKE_EVENT_STATUS:
        begin
          s_d.rdata = {5'h00, s_q.wk_stat};
          clr_wk    = 1'b1;
        end
        ADDR_ALT_WAKE_EVENT_STATUS:
        begin
          s_d.rdata = {6'h00, s_q.alt_stat};
          clr_alt   = 1'b1;
        end
        ADDR_PIN_LEVEL_STATUS: s_d.rdata = {5'h00, s_q.lvl};
        ADDR_MODE_CTRL: s_d.rdata = {6'h00, i_mode};
        ADDR_FAULT_STATUS:
        begin
          s_d.rdata = {7'h00, s_q.fault};
          clr_flt   = 1'b1;
        end
        default: s_d.rdata = 8'h00;
      endcase
    end
    if (clr_wk)
      s_d.wk_stat = '0;
    if (clr_alt)
      s_d.alt_stat = '0;
    if (clr_flt)
      s_d.fault = 1'b0;

    // ****************************************
    // sense and filter
    // ****************************************
    s_d.sync1 = raw;
    s_d.sync2 = s_q.sync1;
    for (int i = 0; i < NCH; i++)
    begin
      if (i < 3)
      begin
        fc = s_q.filt[2*i +: 2];
        unique case (fc)
          FLT_CYCLIC_A: win[i] = i_cycle_timer_a_window;
          FLT_CYCLIC_B: win[i] = i_cycle_timer_b_window;
          default: win[i] = 1'b1;
        endcase
        gate[i] = s_q.meas_en && (i < 2);
        act     = win[i] && !gate[i];
        lim     = (fc == FLT_STATIC_LONG) ? FILTER_CNT_W'(FILTER_LONG_CYC)
                                          : FILTER_CNT_W'(FILTER_SHORT_CYC);
      end
      else
      begin
        act = i_alt_pins_as_wake;
        lim = FILTER_CNT_W'(FILTER_SHORT_CYC);
      end
      if (!act)
      begin
        s_d.cnt[i]   = '0;
        s_d.armed[i] = 1'b0;
        // stable resyncs silently so a window opening is no edge
        s_d.stable[i] = s_q.sync2[i];
        s_d.qual[i]   = s_q.sync2[i];
      end
      else if (s_q.sync2[i] != s_q.stable[i])
      begin
        // any further crossing restarts the interval
        s_d.stable[i] = s_q.sync2[i];
        s_d.cnt[i]    = '0;
        // back at the qualified level: the pulse was a glitch, drop it
        s_d.armed[i]  = s_q.sync2[i] != s_q.qual[i];
      end
      else if (s_q.armed[i])
      begin
        if (s_q.cnt[i] == lim - FILTER_CNT_W'(1))
        begin
          s_d.armed[i] = 1'b0;
          s_d.qual[i]  = s_q.stable[i];
          ev[i]        = 1'b1;
        end
        else
          s_d.cnt[i] = s_q.cnt[i] + FILTER_CNT_W'(1);
      end
    end

    // ****************************************
    // status, bias, wake
    // ****************************************
    s_d.irq  = 1'b0;
    s_d.wake = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      if (!gate[i])
      begin
        if (win[i] && !low_power)
          s_d.lvl[i] = s_q.sync2[i];
        if (ev[i] && s_q.wake_en[i])
        begin
          s_d.wk_stat[i] = 1'b1;
          s_d.irq        = !low_power;
          s_d.wake       = low_power;
        end
      end
      bc = s_q.bias[2*i +: 2];
      s_d.pu[i] = !gate[i] && ((bc == BIAS_UP) || (bc == BIAS_AUTO && s_q.sync2[i]));
      s_d.pd[i] = !gate[i] && ((bc == BIAS_DOWN) || (bc == BIAS_AUTO && !s_q.sync2[i]));
    end
    for (int j = 0; j < 2; j++)
    begin
      if (ev[3+j])
      begin
        s_d.alt_stat[j] = 1'b1;
        s_d.irq         = s_d.irq || !low_power;
        s_d.wake        = s_d.wake || low_power;
      end
    end

    s_d.sw      = s_q.meas_en && (mode == MODE_NORMAL);
    s_d.restart = 1'b0;
    if (i_sleep_cmd && s_q.meas_en && (s_q.wake_en[2:0] != 3'h0) && !s_q.wake_en[2])
    begin
      s_d.fault   = 1'b1;
      s_d.restart = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      s_q         <= '0;
      s_q.wake_en <= RST_WAKE_ENABLE;
      s_q.bias    <= RST_BIAS;
      s_q.filt    <= RST_FILTER;
      s_q.meas_en <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  assign o_rdata          = s_q.rdata;
  assign o_pull_up_en     = s_q.pu;
  assign o_pull_down_en   = s_q.pd;
  assign o_measure_switch = s_q.sw;
  assign o_irq_req        = s_q.irq;
  assign o_wake_req       = s_q.wake;
  assign o_cmd_fault      = s_q.fault;
  assign o_restart_req    = s_q.restart;

endmodule : wim_wake_input_monitor

/* File: verification/wim_pin_model.sv */
`timescale 1ns/100ps
module wim_pin_model (
  input  wire logic       i_clk,
  input  wire logic [4:0] i_level,
  output logic      [2:0] o_wake_input_pin,
  output logic      [1:0] o_alt_fail_output_pins
);
  // *****
  // comparators
  // *****
  // one cycle of wire and comparator delay, never ahead of the request
  always_ff @(posedge i_clk)
  begin
    {o_alt_fail_output_pins, o_wake_input_pin} <= i_level;
  end
endmodule : wim_pin_model

/* File: verification/wim_checker.sv */
`timescale 1ns/100ps
module wim_checker
  import wim_pkg::*;
(
  input wire logic       i_clk, i_resetn, i_wr, i_rd, i_sleep_cmd, i_alt_pins_as_wake,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata, o_rdata,
  input wire logic [2:0] i_wake_input_pin, o_pull_up_en, o_pull_down_en,
  input wire logic [1:0] i_alt_fail_output_pins, i_mode,
  input wire logic       i_cycle_timer_a_window, i_cycle_timer_b_window, o_measure_switch,
  input wire logic       o_irq_req, o_wake_req, o_cmd_fault, o_restart_req
);
  // *****
  // assertions
  // *****
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  irq_pulse_a: assert property (o_irq_req |=> !o_irq_req)
    else $error("irq pulse too long");
  irq_mode_a: assert property (o_irq_req |-> !$past(i_mode[1]))
    else $error("irq outside normal or stop");
  wake_mode_a: assert property (o_wake_req |-> $past(i_mode[1]) && !o_irq_req)
    else $error("wake outside sleep or fail-safe");
  switch_mode_a: assert property (o_measure_switch |-> $past(i_mode) == 2'h0)
    else $error("switch closed outside normal");
  meas_bias_a: assert property (o_measure_switch [*2] |-> (o_pull_up_en[1:0] | o_pull_down_en[1:0]) == 2'h0)
    else $error("bias on measured pins");
  bias_excl_a: assert property ((o_pull_up_en & o_pull_down_en) == 3'h0)
    else $error("pull up and down together");
  restart_fault_a: assert property (o_restart_req |-> o_cmd_fault)
    else $error("restart without fault");
  fault_cause_a: assert property ($rose(o_cmd_fault) |-> $past(i_sleep_cmd) || $past(i_sleep_cmd, 2))
    else $error("fault without sleep command");
  fault_hold_a: assert property (o_cmd_fault && !(i_rd && i_addr == ADDR_FAULT_STATUS) |=> o_cmd_fault)
    else $error("fault dropped without read");
  rdata_hold_a: assert property ($past(i_resetn) && !$past(i_rd) |-> $stable(o_rdata))
    else $error("read data moved without read");
  unmapped_a: assert property ($past(i_rd) && $past(i_addr) > 4'h8 |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");

  cover property (o_irq_req);
  cover property (o_wake_req);
  cover property (o_restart_req);
endmodule : wim_checker

bind wim_wake_input_monitor wim_checker u_chk (.*);

/* File: verification/wim_wake_input_monitor_tb.sv */
`timescale 1ns/100ps
module wim_wake_input_monitor_tb
  import wim_pkg::*;
;
  logic        i_clk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, i_sleep_cmd = 0;
  logic        i_alt_pins_as_wake = 0, i_cycle_timer_a_window = 0, i_cycle_timer_b_window = 0;
  logic [3:0]  i_addr = 0;
  logic [7:0]  i_wdata = 0, o_rdata, x;
  logic [1:0]  i_mode = 0, i_alt_fail_output_pins;
  logic [2:0]  i_wake_input_pin, o_pull_up_en, o_pull_down_en;
  logic        o_measure_switch, o_irq_req, o_wake_req, o_cmd_fault, o_restart_req;
  logic [4:0]  lvl = 0;
  logic [31:0] seed = 32'hDD68DD80, r;
  int          failures = 0, total_checks = 0, cyc = 0;

  wim_wake_input_monitor dut (.*);
  wim_pin_model pm (.i_clk, .i_level(lvl), .o_wake_input_pin(i_wake_input_pin),
                    .o_alt_fail_output_pins(i_alt_fail_output_pins));

  // *****
  // helpers
  // *****
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      final_report();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // {down, up} per pin for a bias word and pin levels
  function automatic logic [5:0] bias_exp(input logic [5:0] w, input logic [2:0] l);
    for (int i = 0; i < 3; i++)
    begin
      bias_exp[i] = w[2*i+:2] == BIAS_UP || (w[2*i+:2] == BIAS_AUTO && l[i]);
      bias_exp[i+3] = w[2*i+:2] == BIAS_DOWN || (w[2*i+:2] == BIAS_AUTO && !l[i]);
    end
  endfunction : bias_exp

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
    d = o_rdata;
  endtask : rd

  // toggle input b, optionally toggle back after g cycles, look for a pulse n cycles on
  task automatic ev(input int b, input int n, input int g, input logic e);
    int c;
    c = 0;
    lvl[b] <= ~lvl[b];
    for (int k = 1; k <= n + g + 20; k++)
    begin
      @(posedge i_clk);
      if (k == g) lvl[b] <= ~lvl[b];
      if (c == 0 && (o_irq_req | o_wake_req) === 1'b1) c = k;
    end
    chk({7'h00, e ? (c >= n && c <= n + 12) : c != 0}, {7'h00, e});
    rd(b < 3 ? ADDR_WAKE_EVENT_STATUS : ADDR_ALT_WAKE_EVENT_STATUS, x);
    chk(x, e ? 8'h01 << (b % 3) : 8'h00);
    rd(b < 3 ? ADDR_WAKE_EVENT_STATUS : ADDR_ALT_WAKE_EVENT_STATUS, x);
    chk(x, 8'h00);
  endtask : ev

  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  // *****
  // scenarios
  // *****
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    for (int a = 0; a < 4; a++)
    begin
      rd(a[3:0], x);
      chk(x, 8'h00);
    end
    rd(4'hF, x);
    chk(x, 8'h00);
    $display("end reset values");
    for (int i = 0; i < 9; i++)
    begin
      r = rnd();
      if (i == 0) r = '1;
      lvl <= r[4:0];
      wr(ADDR_BIAS_CURRENT_CTRL, {2'h0, r[10:5]});
      repeat (6) @(posedge i_clk);
      chk({2'h0, o_pull_down_en, o_pull_up_en}, {2'h0, bias_exp(r[10:5], r[2:0])});
      rd(ADDR_PIN_LEVEL_STATUS, x);
      chk(x, {5'h00, r[2:0]});
    end
    // let filters started by the random levels run out before enabling wake
    repeat (FILTER_SHORT_CYC + 10) @(posedge i_clk);
    $display("end bias and level");
    wr(ADDR_WAKE_ENABLE_CTRL, 8'h07);
    for (int f = 0; f < 4; f++)
    begin
      wr(ADDR_FILTER_MODE_CTRL, {2'h0, f[1:0], 4'h0});
      i_cycle_timer_a_window <= f == 2;
      i_cycle_timer_b_window <= f == 3;
      ev(2, f == 1 ? FILTER_LONG_CYC : FILTER_SHORT_CYC, 0, 1'b1);
    end
    i_cycle_timer_a_window <= 1'b1;
    i_cycle_timer_b_window <= 1'b0;
    ev(2, FILTER_SHORT_CYC, 0, 1'b0);
    rd(ADDR_PIN_LEVEL_STATUS, x);
    chk({7'h00, x[2]}, {7'h00, ~lvl[2]});
    wr(ADDR_FILTER_MODE_CTRL, 8'h00);
    $display("end filter codes");
    i_alt_pins_as_wake <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      r = rnd();
      ev(r % 5, FILTER_SHORT_CYC, 0, 1'b1);
    end
    ev(0, FILTER_SHORT_CYC, 100, 1'b0);
    wr(ADDR_WAKE_ENABLE_CTRL, 8'h03);
    ev(2, FILTER_SHORT_CYC, 0, 1'b0);
    i_mode <= MODE_SLEEP;
    ev(1, FILTER_SHORT_CYC, 0, 1'b1);
    $display("end static wake");
    i_mode <= MODE_NORMAL;
    wr(ADDR_MEASURE_CTRL, 8'h01);
    wr(ADDR_BIAS_CURRENT_CTRL, 8'h3F);
    repeat (4) @(posedge i_clk);
    chk({3'h0, o_measure_switch, o_pull_down_en[1:0], o_pull_up_en[1:0]}, 8'h10);
    ev(0, FILTER_SHORT_CYC, 0, 1'b0);
    rd(ADDR_BIAS_CURRENT_CTRL, x);
    chk(x, 8'h3F);
    i_mode <= MODE_SLEEP;
    i_sleep_cmd <= 1'b1;
    @(posedge i_clk);
    i_sleep_cmd <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk({7'h00, o_measure_switch}, 8'h00);
    rd(ADDR_FAULT_STATUS, x);
    chk(x, 8'h01);
    rd(ADDR_FAULT_STATUS, x);
    chk(x, 8'h00);
    $display("end measurement");
    final_report();
  end
endmodule : wim_wake_input_monitor_tb
